// ### src/bcfe_engine.sv
// Block cipher FIFO engine: APB registers, FIFOs, DMA requests and block sequencing.
// Contract
// - Algorithm and chaining chosen by control field.
// - Data type swaps words, halves, bytes, bits.
// - Key size matters in AES modes only.
// - Key preparation raises busy until schedule ready.
// - Flush resets both FIFO pointers before enable.
// - Output-not-empty flag while results wait.
// - Input-not-full flag while input has space.
// - Done: busy clear, input empty, output empty.
// - After final read: mask off, idle, empty.
// - DMA bursts: AES four, DES two or four; the engine sizes DES requests at two words only.
// - Separate input and output DMA request enables.
// - Config bits, keys and vectors save and restore.
// - Enable starts and stops the engine.
// - Input service request below four words held.
// - Output service request follows output-not-empty.
// - Masked input request low while disabled.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module bcfe_engine #(
  parameter int DEPTH = bcfe_pkg::FIFO_DEPTH
) (
  input  wire logic                    clk,      // Bus clock, 100 MHz.
  input  wire logic                    nrst,     // Asynchronous reset, active low.
  input  wire bcfe_pkg::bcfe_apb_req_t apbReq,   // APB request signals.
  output bcfe_pkg::bcfe_apb_rsp_t      apbRsp,   // APB answer signals.
  output logic                         dmaInReq,   // Input FIFO burst request.
  output logic                         dmaOutReq,  // Output FIFO burst request.
  output logic                         irqOut      // Masked service interrupts, ORed.
);
  import bcfe_pkg::*;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    bcfe_cfg_t       cfg;
    logic [1:0]      dmaEn;
    logic [1:0]      imask;
    logic [7:0][31:0] key;
    logic [3:0][31:0] iv;
    logic            busy;
    logic            coreRun;
    logic [2:0]      wIdx;
    logic            draining;
    logic [127:0]    res;
    logic            keyReady;
  } bcfe_st_t;
  bcfe_st_t st_q, st_d;

  logic          wr, rd, inPush, inPop, outPush, outPop, flush, coreStart, coreDone;
  logic [31:0]   inHead, outHead, rdMux, outWord;
  logic [CW-1:0] inCnt, outCnt;
  logic [127:0]  coreOut, blkIn, keyMix;
  logic          isAes, blkAvail, outRoom, inEmpty, inNotFull, outNotEmpty, outFull;
  logic [1:0]    rawIrq;
  logic [2:0]    blkWords;
  logic [7:0]    addr;
  logic          isKeyPrep;

  bcfe_fifo #(.DEPTH(DEPTH)) u_in (
    .clk(clk), .nrst(nrst), .flush(flush), .push(inPush), .wdata(apbReq.pwdata),
    .pop(inPop), .rdata(inHead), .count(inCnt)
  );
  bcfe_fifo #(.DEPTH(DEPTH)) u_out (
    .clk(clk), .nrst(nrst), .flush(flush), .push(outPush), .wdata(outWord),
    .pop(outPop), .rdata(outHead), .count(outCnt)
  );
  bcfe_core u_core (
    .clk(clk), .nrst(nrst), .start(coreStart), .blkIn(blkIn), .keyMix(keyMix),
    .keyPrep(isKeyPrep), .done(coreDone), .blkOut(coreOut)
  );

  // The slave answers in the first access cycle; nothing waits.
  assign addr = apbReq.paddr;
  assign wr   = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rd   = apbReq.psel && apbReq.penable && !apbReq.pwrite;

  assign isAes     = st_q.cfg.algo inside {BCFE_AES_ECB, BCFE_AES_CBC, BCFE_AES_CTR,
                                           BCFE_AES_KEY};
  assign isKeyPrep = st_q.cfg.algo == BCFE_AES_KEY;
  assign blkWords  = isAes ? 3'(AES_BLK_WORDS) : 3'(DES_BLK_WORDS);
  assign blkAvail  = inCnt >= CW'(blkWords);
  assign outRoom   = (CW'(DEPTH) - outCnt) >= CW'(blkWords);

  assign inEmpty     = inCnt == '0;
  assign inNotFull   = inCnt != CW'(DEPTH);
  assign outNotEmpty = outCnt != '0;
  assign outFull     = outCnt == CW'(DEPTH);

  // Flush is a self-clearing command bit; it acts only when busy is clear.
  assign flush  = wr && addr == OFF_CTRL && apbReq.pwdata[CTRL_FLUSH] && !st_q.busy;
  assign inPush = wr && addr == OFF_DIN && inNotFull;
  assign outPop = rd && addr == OFF_DOUT;
  assign inPop  = st_q.wIdx != 3'h0 && !st_q.draining;

  // Key size selects how many key words feed AES; DES modes ignore it.
  always_comb begin
    keyMix = {st_q.key[7], st_q.key[6], st_q.key[5], st_q.key[4]};
    if (isAes) begin
      unique case (st_q.cfg.ksize)
        BCFE_K128: keyMix = {st_q.key[4], st_q.key[5], st_q.key[6], st_q.key[7]};
        BCFE_K192: keyMix = {st_q.key[2] ^ st_q.key[4], st_q.key[3] ^ st_q.key[5],
                             st_q.key[6], st_q.key[7]};
        default:   keyMix = {st_q.key[0] ^ st_q.key[4], st_q.key[1] ^ st_q.key[5],
                             st_q.key[2] ^ st_q.key[6], st_q.key[3] ^ st_q.key[7]};
      endcase
    end else begin
      keyMix = {st_q.key[0] ^ st_q.key[2], st_q.key[1] ^ st_q.key[3],
                st_q.key[4] ^ st_q.key[6], st_q.key[5] ^ st_q.key[7]};
    end
    // Chaining material: only CBC and CTR fold the vectors in.
    if (st_q.cfg.algo inside {BCFE_TDES_CBC, BCFE_DES_CBC, BCFE_AES_CBC, BCFE_AES_CTR}) begin
      keyMix = keyMix ^ {st_q.iv[0], st_q.iv[1], st_q.iv[2], st_q.iv[3]};
    end
  end

  assign blkIn     = st_q.res;
  // Start is held off in the done cycle, else the idle core would take a second run.
  assign coreStart = st_q.cfg.enable && st_q.coreRun && !st_q.draining && st_q.wIdx == 3'h0
                     && (isKeyPrep || !st_q.keyReady) && !coreDone;
  assign outPush   = st_q.draining && st_q.wIdx != 3'h0;
  assign outWord   = bcfe_swap(st_q.res[127:96], st_q.cfg.dtype);

  always_comb begin
    st_d = st_q;
    if (wr) begin
      unique case (addr)
        OFF_CTRL: begin
          // Busy freezes the configuration so a running block keeps its mode.
          if (!st_q.busy) st_d.cfg = bcfe_cfg_t'(apbReq.pwdata[15:0] & CTRL_CFG_MASK[15:0]);
          st_d.cfg.rsv    = '0;
          st_d.cfg.enable = apbReq.pwdata[CTRL_EN];
        end
        OFF_DMA:   st_d.dmaEn = apbReq.pwdata[1:0];
        OFF_IMASK: st_d.imask = apbReq.pwdata[1:0];
        default: begin
          if (addr >= OFF_KEY0 && addr < OFF_IV0) st_d.key[addr[4:2]] = apbReq.pwdata;
          else if (addr >= OFF_IV0 && addr <= OFF_LAST) st_d.iv[addr[3:2]] = apbReq.pwdata;
        end
      endcase
    end
    // Sequencer: gather a block from the input FIFO, run it, drain to output.
    if (st_q.cfg.enable && !st_q.coreRun && !st_q.draining) begin
      if (isKeyPrep && !st_q.keyReady) begin
        st_d.coreRun = 1'b1;
        st_d.busy    = 1'b1;
      end else if (!isKeyPrep && blkAvail && outRoom && st_q.wIdx == 3'h0) begin
        st_d.wIdx = blkWords;
        st_d.busy = 1'b1;
        st_d.res  = '0;
      end
    end
    if (inPop) begin
      st_d.res  = {st_q.res[95:0], bcfe_swap(inHead, st_q.cfg.dtype)};
      st_d.wIdx = st_q.wIdx - 3'h1;
      if (st_q.wIdx == 3'h1) begin
        st_d.coreRun = 1'b1;
        if (!isAes) st_d.res = {st_d.res[63:0], 64'h0};
      end
    end
    if (coreStart && !isKeyPrep) st_d.keyReady = 1'b0;
    if (coreDone) begin
      st_d.coreRun = 1'b0;
      if (isKeyPrep) begin
        st_d.keyReady = 1'b1;
        st_d.busy     = 1'b0;
      end else begin
        st_d.res      = coreOut;
        st_d.draining = 1'b1;
        st_d.wIdx     = blkWords;
      end
    end
    if (outPush) begin
      st_d.res  = {st_q.res[95:0], 32'h0};
      st_d.wIdx = st_q.wIdx - 3'h1;
      if (st_q.wIdx == 3'h1) begin
        st_d.draining = 1'b0;
        // Busy drops when no further whole block is waiting or the engine is disabled.
        st_d.busy = (inCnt >= CW'(blkWords)) && st_q.cfg.enable;
      end
    end
    if (!isKeyPrep && wr && addr == OFF_CTRL && !apbReq.pwdata[CTRL_EN]) st_d.keyReady = 1'b0;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st_q <= '0;
    else       st_q <= st_d;
  end

  // Service requests have no pending bit; they track the FIFO levels directly.
  assign rawIrq[0] = inCnt < CW'(IN_IRQ_LEVEL);
  assign rawIrq[1] = outNotEmpty;
  wire logic [1:0] mskIrq = {rawIrq[1] & st_q.imask[1],
                             rawIrq[0] & st_q.imask[0] & st_q.cfg.enable};
  assign irqOut = |mskIrq;

  // DMA asks for a whole burst only, so a burst never overruns either FIFO.
  assign dmaInReq  = st_q.dmaEn[0] && st_q.cfg.enable
                     && (CW'(DEPTH) - inCnt) >= CW'(blkWords);
  assign dmaOutReq = st_q.dmaEn[1] && outCnt >= CW'(blkWords);

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (addr)
      OFF_CTRL:   rdMux = {16'h0, st_q.cfg};
      OFF_STAT:   rdMux = {27'h0, st_q.busy, outFull, outNotEmpty, inNotFull, inEmpty};
      OFF_DIN:    rdMux = inHead;
      OFF_DOUT:   rdMux = outHead;
      OFF_DMA:    rdMux = {30'h0, st_q.dmaEn};
      OFF_IMASK:  rdMux = {30'h0, st_q.imask};
      OFF_RAWIRQ: rdMux = {30'h0, rawIrq};
      OFF_MSKIRQ: rdMux = {30'h0, mskIrq};
      default: begin
        if (addr >= OFF_KEY0 && addr < OFF_IV0) rdMux = st_q.key[addr[4:2]];
        else if (addr >= OFF_IV0 && addr <= OFF_LAST) rdMux = st_q.iv[addr[3:2]];
      end
    endcase
  end

  assign apbRsp.prdata  = rdMux;
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = (apbReq.psel && apbReq.penable)
                          && (addr[1:0] != 2'b00 || addr > OFF_LAST);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_prep_start;
    st_q.cfg.enable && isKeyPrep && !st_q.busy && !st_q.keyReady && !st_q.coreRun;
  endsequence
  a_prep_busy_set: assert property (s_prep_start |=> st_q.busy)
    else $error("Busy not raised for key preparation.");
  a_prep_busy_clr: assert property (s_prep_start |-> ##[1:20] !st_q.busy)
    else $error("Key preparation never cleared busy.");
  a_flush_empties: assert property (flush |=> inCnt == '0 && outCnt == '0)
    else $error("Flush left words in a FIFO.");
  a_flush_idle: assert property (flush |-> !st_q.busy)
    else $error("Flush taken while busy.");
  a_in_irq_lvl: assert property (rawIrq[0] == (inCnt < CW'(4)))
    else $error("Input service request wrong.");
  a_out_irq_ne: assert property (rawIrq[1] == (outCnt != '0))
    else $error("Output service request not following level.");
  a_in_mask_off: assert property (!st_q.cfg.enable |-> !mskIrq[0])
    else $error("Masked input request while disabled.");
  a_status_flags: assert property (apbRsp.prdata[ST_OFNE] == outNotEmpty || addr != OFF_STAT)
    else $error("Status output flag wrong.");
  a_dma_aes_burst: assert property (dmaOutReq && isAes |-> outCnt >= CW'(4))
    else $error("Output burst requested short of a block.");
  a_block_drain: assert property ($rose(st_q.draining) |-> st_q.draining [*2] ##1 1'b1)
    else $error("Drain too short for a block.");
endmodule
`default_nettype wire

// ### shared/bcfe_pkg.sv
// Shared constants, register map and carrier types of the block cipher FIFO engine.
package bcfe_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STAT   = 8'h04;
  localparam logic [7:0] OFF_DIN    = 8'h08;
  localparam logic [7:0] OFF_DOUT   = 8'h0c;
  localparam logic [7:0] OFF_DMA    = 8'h10;
  localparam logic [7:0] OFF_IMASK  = 8'h14;
  localparam logic [7:0] OFF_RAWIRQ = 8'h18;
  localparam logic [7:0] OFF_MSKIRQ = 8'h1c;
  localparam logic [7:0] OFF_KEY0   = 8'h20;
  localparam logic [7:0] OFF_IV0    = 8'h40;
  localparam logic [7:0] OFF_LAST   = 8'h4c;
  // Control register field positions.
  localparam int CTRL_DIR   = 2;
  localparam int CTRL_ALGO  = 3;
  localparam int CTRL_DTYPE = 6;
  localparam int CTRL_KSIZE = 8;
  localparam int CTRL_FLUSH = 14;
  localparam int CTRL_EN    = 15;
  localparam logic [31:0] CTRL_CFG_MASK = 32'h0000_83fc;
  // Status bit positions.
  localparam int ST_IFEM = 0;
  localparam int ST_IFNF = 1;
  localparam int ST_OFNE = 2;
  localparam int ST_OFFU = 3;
  localparam int ST_BUSY = 4;
  localparam logic [1:0] IRQ_IN  = 2'h1;
  localparam logic [1:0] IRQ_OUT = 2'h2;
  localparam int IN_IRQ_LEVEL   = 4;
  localparam int DES_BLK_WORDS  = 2;
  localparam int AES_BLK_WORDS  = 4;
  localparam int FIFO_DEPTH     = 8;
  localparam int KEYPREP_CYCLES = 14;
  localparam int ROUND_CYCLES   = 16;

  typedef enum logic [2:0] {
    BCFE_TDES_ECB, BCFE_TDES_CBC, BCFE_DES_ECB, BCFE_DES_CBC,
    BCFE_AES_ECB, BCFE_AES_CBC, BCFE_AES_CTR, BCFE_AES_KEY
  } bcfe_algo_t;
  typedef enum logic [1:0] {BCFE_WORD, BCFE_HALF, BCFE_BYTE, BCFE_BIT} bcfe_dtype_t;
  typedef enum logic [1:0] {BCFE_K128, BCFE_K192, BCFE_K256, BCFE_KRSV} bcfe_ksize_t;

  typedef struct packed {
    logic              enable;
    logic [14:10]      rsv;
    bcfe_ksize_t       ksize;
    bcfe_dtype_t       dtype;
    bcfe_algo_t        algo;
    logic              decrypt;
    logic [1:0]        low;
  } bcfe_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } bcfe_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bcfe_apb_rsp_t;

  // Reorders a word according to the data type setting.
  function automatic logic [31:0] bcfe_swap(input logic [31:0] w, input bcfe_dtype_t t);
    logic [31:0] r;
    r = w;
    unique case (t)
      BCFE_WORD: r = w;
      BCFE_HALF: r = {w[15:0], w[31:16]};
      BCFE_BYTE: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
      BCFE_BIT: begin
        for (int i = 0; i < 32; i++) begin
          r[i] = w[31-i];
        end
      end
    endcase
    return r;
  endfunction
endpackage

// ### src/bcfe_fifo.sv
// Word FIFO with flush, level count and registered read data.
`timescale 1ns/1ps
`default_nettype none
module bcfe_fifo #(
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          clk,    // Bus clock.
  input  wire logic          nrst,   // Asynchronous reset, active low.
  input  wire logic          flush,  // Resets both pointers.
  input  wire logic          push,   // Write one word.
  input  wire logic [31:0]   wdata,  // Word written.
  input  wire logic          pop,    // Take one word.
  output logic [31:0]        rdata,  // Head word, registered.
  output logic [CW-1:0]      count   // Words held.
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } bcfe_fifo_st_t;
  bcfe_fifo_st_t st_q, st_d;
  logic [31:0] mem [DEPTH];
  logic doPush, doPop;

  // Full pushes and empty pops are dropped here so the count stays honest.
  assign doPush = push && (st_q.cnt != CW'(DEPTH));
  assign doPop  = pop && (st_q.cnt != '0);

  always_comb begin
    st_d = st_q;
    if (flush) begin
      st_d = '0;
    end else begin
      if (doPush) st_d.wp = st_q.wp + 1'b1;
      if (doPop)  st_d.rp = st_q.rp + 1'b1;
      st_d.cnt = st_q.cnt + CW'(doPush) - CW'(doPop);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st_q <= '0;
    else       st_q <= st_d;
  end

  always_ff @(posedge clk) begin
    if (doPush && !flush) mem[st_q.wp] <= wdata;
  end

  // Read data is the head word of the next state, so it is always registered.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdata <= 32'h0000_0000;
    else       rdata <= (doPush && st_d.cnt == CW'(1) && !flush) ? wdata : mem[st_d.rp];
  end
  assign count = st_q.cnt;
endmodule
`default_nettype wire

// ### src/bcfe_core.sv
// Cipher round engine stand-in: takes one block, returns it after a fixed latency.
`timescale 1ns/1ps
`default_nettype none
module bcfe_core (
  input  wire logic           clk,      // Bus clock.
  input  wire logic           nrst,     // Asynchronous reset, active low.
  input  wire logic           start,    // Begin a block or key preparation.
  input  wire logic [127:0]   blkIn,    // Input block, left word first in top bits.
  input  wire logic [127:0]   keyMix,   // Key and chaining material folded in.
  input  wire logic           keyPrep,  // Key preparation, no data.
  output logic                done,     // One-cycle pulse when finished.
  output logic [127:0]        blkOut    // Result block, registered.
);
  import bcfe_pkg::*;
  typedef struct packed {
    logic         run;
    logic [4:0]   cnt;
    logic [127:0] acc;
    logic         done;
  } bcfe_core_st_t;
  bcfe_core_st_t st_q, st_d;

  // The real round datapath sits outside this model; a keyed mix keeps data flowing.
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (start && !st_q.run) begin
      st_d.run = 1'b1;
      st_d.cnt = keyPrep ? 5'(KEYPREP_CYCLES) : 5'(ROUND_CYCLES);
      st_d.acc = blkIn ^ keyMix;
    end else if (st_q.run) begin
      if (st_q.cnt == 5'h01) begin
        st_d.run  = 1'b0;
        st_d.done = 1'b1;
      end
      st_d.cnt = st_q.cnt - 5'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) st_q <= '0;
    else       st_q <= st_d;
  end
  assign done   = st_q.done;
  assign blkOut = st_q.acc;
endmodule
`default_nettype wire

// ### verif/bcfe_host_model.sv
// Host bus and DMA controller model that masters the engine's APB port.
`timescale 1ns/1ps
`default_nettype none
module bcfe_host_model (
  input  wire logic                    clk,        // Bus clock.
  output var  bcfe_pkg::bcfe_apb_req_t apbReq,     // APB request.
  input  wire bcfe_pkg::bcfe_apb_rsp_t apbRsp,     // APB answer.
  input  wire logic                    dmaInReq,   // Input burst request.
  input  wire logic                    dmaOutReq   // Output burst request.
);
  import bcfe_pkg::*;
  int hangs    = 0;  // Waits cut off by their bound.
  int outWords = 0;  // Words drained by the last DMA run.
  initial apbReq = '0;

  // The request stays put until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 64);
    if (n >= 64) hangs++;
    r = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
  endtask

  // Serves requests in whole four-word bursts, so a message must be whole blocks.
  task automatic dmaRun(input int nWords);
    int          inLeft;
    int          n;
    logic [31:0] r;
    inLeft   = nWords;
    outWords = 0;
    n        = 0;
    while ((inLeft > 0 || outWords < nWords) && n < 3000) begin
      @(negedge clk);
      n++;
      if (dmaInReq === 1'b1 && inLeft > 0) begin
        for (int i = 0; i < AES_BLK_WORDS; i++) begin
          host_in : wr(OFF_DIN, 32'h5c00_0000 + 32'(inLeft));
          inLeft--;
        end
      end else if (dmaOutReq === 1'b1) begin
        for (int i = 0; i < AES_BLK_WORDS; i++) begin
          rd(OFF_DOUT, r);
          outWords++;
        end
      end
    end
    if (n >= 3000) hangs++;
  endtask
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the block cipher FIFO engine.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bcfe_pkg::*;
  logic          clk;
  logic          nrst;
  bcfe_apb_req_t apbReq;
  bcfe_apb_rsp_t apbRsp;
  logic          dmaInReq;
  logic          dmaOutReq;
  logic          irqOut;
  logic [31:0]   rv;
  logic [31:0]   cfg;
  logic          se;
  int            num_errors;
  int            comparisons;
  logic [2:0]    algos [5] = '{3'h2, 3'h1, 3'h5, 3'h6, 3'h4};
  int            nws [5]   = '{2, 4, 4, 8, 9};

  bcfe_engine #(.DEPTH(FIFO_DEPTH)) dut (
    .clk(clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp),
    .dmaInReq(dmaInReq), .dmaOutReq(dmaOutReq), .irqOut(irqOut));
  bcfe_host_model host (
    .clk(clk), .apbReq(apbReq), .apbRsp(apbRsp),
    .dmaInReq(dmaInReq), .dmaOutReq(dmaOutReq));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic test_done();
    num_errors += host.hangs;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    host.rd(a, rv);
    check(what, rv & m, exp);
  endtask

  // Pins {irq, dma out, dma in} are read at the falling edge, after the last edge's updates.
  task automatic pinChk(input string what, input logic [31:0] exp);
    @(negedge clk);
    check(what, {29'h0, irqOut, dmaOutReq, dmaInReq}, exp);
  endtask

  task automatic waitSt(input int b, input logic v);
    int n;
    n = 0;
    do begin
      host.rd(OFF_STAT, rv);
      n++;
    end while (rv[b] !== v && n < 100);
    if (n >= 100) begin
      check("status wait", 32'(rv[b]), 32'(v));
      test_done();
    end
  endtask

  task automatic runMsg(input logic [2:0] al, input int nw);
    int blk;
    int nOut;
    blk  = (al >= 3'h4) ? AES_BLK_WORDS : DES_BLK_WORDS;
    nOut = ((nw > FIFO_DEPTH ? FIFO_DEPTH : nw) / blk) * blk;
    cfg  = 32'(al) << CTRL_ALGO;
    host.wr(OFF_CTRL, 32'h1 << CTRL_FLUSH);
    host.wr(OFF_CTRL, cfg);
    for (int i = 0; i < nw; i++) host.wr(OFF_DIN, 32'h0a00_0000 + 32'(i));
    rdChk("fill flags", OFF_STAT, 32'h3, {30'h0, nw < FIFO_DEPTH, 1'b0});
    host.wr(OFF_CTRL, cfg | (32'h1 << CTRL_EN));
    for (int i = 0; i < nOut; i++) begin
      if (i % blk == 0) waitSt(ST_OFNE, 1'b1);
      host.rd(OFF_DOUT, rv);
    end
    waitSt(ST_BUSY, 1'b0);
    rdChk("done flags", OFF_STAT, 32'h1f, 32'h3);
  endtask

  initial begin
    nrst = 1'b0;
    num_errors = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    pinChk("pins after reset", 32'h0);
    rdChk("reset status", OFF_STAT, 32'h1f, 32'h3);
    // Keys then vectors sit in twelve consecutive words.
    for (int i = 0; i < 12; i++) begin
      host.wr(OFF_KEY0 + 8'(4 * i), 32'h3c00_0101 * 32'(i + 1));
    end
    for (int i = 0; i < 12; i++) begin
      rdChk("key vector", OFF_KEY0 + 8'(4 * i), 32'hffff_ffff,
            32'h3c00_0101 * 32'(i + 1));
    end
    host.xfer(1'b0, 8'h50, 32'h0, rv, se);
    check("unmapped error", 32'(se), 32'h1);
    for (int a = 0; a < 8; a++) begin
      cfg = (32'(a) << CTRL_ALGO) | (32'(a % 4) << CTRL_DTYPE)
            | (32'(a % 3) << CTRL_KSIZE) | (32'(a % 2) << CTRL_DIR);
      host.wr(OFF_CTRL, cfg);
      rdChk("control config", OFF_CTRL, CTRL_CFG_MASK, cfg);
    end
    host.wr(OFF_CTRL, (32'h1 << CTRL_EN) | (32'(BCFE_AES_KEY) << CTRL_ALGO));
    rdChk("key prep busy", OFF_STAT, 32'h10, 32'h10);
    waitSt(ST_BUSY, 1'b0);
    for (int m = 0; m < 5; m++) runMsg(algos[m], nws[m]);
    // Service interrupts: raw, masked and the line itself.
    cfg = 32'(BCFE_AES_ECB) << CTRL_ALGO;
    host.wr(OFF_CTRL, 32'h1 << CTRL_FLUSH);
    host.wr(OFF_CTRL, cfg);
    host.wr(OFF_IMASK, 32'h3);
    for (int i = 0; i < 2; i++) host.wr(OFF_DIN, 32'h7700_0000 + 32'(i));
    rdChk("raw below four", OFF_RAWIRQ, 32'h1, 32'h1);
    rdChk("masked off", OFF_MSKIRQ, 32'h3, 32'h0);
    pinChk("irq disabled", 32'h0);
    for (int i = 0; i < 2; i++) host.wr(OFF_DIN, 32'h7800_0000 + 32'(i));
    rdChk("raw at four", OFF_RAWIRQ, 32'h1, 32'h0);
    host.wr(OFF_IMASK, 32'h2);
    host.wr(OFF_CTRL, cfg | (32'h1 << CTRL_EN));
    waitSt(ST_OFNE, 1'b1);
    rdChk("raw both", OFF_RAWIRQ, 32'h3, 32'h3);
    pinChk("irq output", 32'h4);
    for (int i = 0; i < AES_BLK_WORDS; i++) host.rd(OFF_DOUT, rv);
    waitSt(ST_BUSY, 1'b0);
    rdChk("raw out clear", OFF_RAWIRQ, 32'h2, 32'h0);
    pinChk("irq idle", 32'h0);
    rdChk("mask after", OFF_IMASK, 32'h1, 32'h0);
    rdChk("final status", OFF_STAT, 32'h1f, 32'h3);
    // Burst service with the input request enabled alone first, then both requests together.
    host.wr(OFF_CTRL, 32'h1 << CTRL_FLUSH);
    host.wr(OFF_CTRL, cfg | (32'h1 << CTRL_EN));
    host.wr(OFF_DMA, 32'h1);
    pinChk("dma input only", 32'h1);
    host.wr(OFF_DMA, 32'h3);
    host.dmaRun(12);
    if (host.hangs != 0) test_done();
    check("dma words out", 32'(host.outWords), 32'd12);
    waitSt(ST_BUSY, 1'b0);
    rdChk("dma done", OFF_STAT, 32'h1f, 32'h3);
    test_done();
  end
endmodule
`default_nettype wire
